// File: osr_pkg.sv
// package for the output source router: source codes, mask layout, reset values
// ----------------------------------------------------------------------------
// Notes on behaviour
// - control output selectors exist only on two-output standard model
// - each control selector routes exactly one source
// - reset: output 1 heating, output 2 disabled
// - heating/cooling mode forces output 2 to cooling
// - cooling under standard control outputs zero percent
// - program end selectable but inactive when pattern off
// - work-bit choices hidden when logic function unused
// - auxiliary selector only for existing auxiliary outputs
// - auxiliary selectors share source list, route one
// - reset: auxiliary outputs pick alarms one to four
// - heater alarm default for aux one with detection
// - compact variant: cooling mode drives auxiliary two
// - large one-output variant: cooling on aux four/two
// - mask matters only when combined fault routed
// - combined fault ORs masked alarm and error flags
// - mask weights: alarms 1-8, break 16, ssr 32, error 64
// - mask range 0 to 255, reset 49
// ----------------------------------------------------------------------------
package osr_pkg;

  typedef enum logic [4:0] {
    OSR_SRC_OFF,
    OSR_SRC_HEAT,
    OSR_SRC_COOL,
    OSR_SRC_LIMIT_ALARM_ONE,
    OSR_SRC_ALM2,
    OSR_SRC_ALM3,
    OSR_SRC_ALM4,
    OSR_SRC_HEATER,
    OSR_SRC_BREAK,
    OSR_SRC_SSR,
    OSR_SRC_INERR,
    OSR_SRC_PEND,
    OSR_SRC_RUN,
    OSR_SRC_COMB,
    OSR_SRC_WB1,
    OSR_SRC_WB2,
    OSR_SRC_WB3,
    OSR_SRC_WB4,
    OSR_SRC_WB5,
    OSR_SRC_WB6,
    OSR_SRC_WB7,
    OSR_SRC_WB8
  } osr_src_t;

  typedef enum logic [1:0] {
    OSR_VAR_STD2,
    OSR_VAR_STD1,
    OSR_VAR_COMPACT
  } osr_var_t;

  // internal sources bundled
  typedef struct packed {
    logic heat;
    logic cool;
    logic [3:0] alarm;
    logic heater_alarm;
    logic heater_break_alarm;
    logic ssr_failure_alarm;
    logic input_error;
    logic program_end;
    logic run_state;
    logic [7:0] work_bits;
  } osr_sources_t;

  localparam int OSR_MASK_W = 8;
  localparam int OSR_MASK_LIMIT_ALARM_ONE = 0;
  localparam int OSR_MASK_BREAK = 4;
  localparam int OSR_MASK_SSR = 5;
  localparam int OSR_MASK_INERR = 6;
  localparam int OSR_MASK_SPARE = 7;
  localparam logic [7:0] OSR_MASK_RST = 8'h31;
  localparam int OSR_AUX_MAX = 4;

endpackage : osr_pkg

// File: osr_selector.sv
// one output source selector with legality filter and registered output
`timescale 1ns/1ns
`default_nettype none
module osr_selector
  import osr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // configuration
  input wire osr_src_t reset_sel_in,
  input wire logic wr_in,
  input wire osr_src_t wr_sel_in,
  input wire logic force_cool_in,
  input wire logic logic_used_in,
  // source levels
  input wire logic [21:0] src_vec_in,
  // result
  output osr_src_t sel_out,
  output logic level_out
);

  osr_src_t sel_r;
  logic level_r;
  logic wr_legal;
  logic is_wb;
  osr_src_t eff_sel;

  assign is_wb = (wr_sel_in >= OSR_SRC_WB1) && (wr_sel_in <= OSR_SRC_WB8);
  // work-bit codes are not offered while the logic function is idle
  assign wr_legal = (wr_sel_in <= OSR_SRC_WB8) && !(is_wb && !logic_used_in);
  // the forced cooling assignment overrides software, it does not only seed it
  assign eff_sel = force_cool_in ? OSR_SRC_COOL : sel_r;

  // reset is synchronous, so the per-output default is loaded straight from the tied-off pin
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sel_r <= reset_sel_in;
    end else if (wr_in && wr_legal) begin
      sel_r <= wr_sel_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      level_r <= 1'b0;
    end else begin
      level_r <= src_vec_in[eff_sel];
    end
  end

  assign sel_out = eff_sel;
  assign level_out = level_r;

endmodule : osr_selector
`default_nettype wire

// File: output_source_router.sv
// top of the output source router: variant handling, combined fault, selectors
`timescale 1ns/1ns
`default_nettype none
module output_source_router
  import osr_pkg::*;
#(
  parameter int AUX_COUNT = 4,
  parameter osr_var_t VARIANT = OSR_VAR_STD2,
  parameter bit HB_HS_FITTED = 1'b0
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // mode and feature settings
  input wire logic heat_cool_mode_in,
  input wire logic program_pattern_on_in,
  input wire logic logic_used_in,
  // selector writes
  input wire logic [1:0] ctrl_wr_in,
  input wire osr_src_t ctrl_sel_in,
  input wire logic [3:0] aux_wr_in,
  input wire osr_src_t aux_sel_in,
  input wire logic mask_wr_in,
  input wire logic [7:0] mask_data_in,
  // internal sources
  input wire osr_sources_t sources_in,
  // outputs
  output logic [1:0] ctrl_out,
  output logic [3:0] aux_out,
  output logic [7:0] combined_fault_mask_out,
  output logic combined_fault_out,
  output osr_src_t ctrl1_sel_out,
  output osr_src_t ctrl2_sel_out
);

  if (AUX_COUNT < 0 || AUX_COUNT > OSR_AUX_MAX) begin : g_bad_aux
    $error("AUX_COUNT out of range");
  end

  // --------------------------------------------------------------------------
  // combined fault
  // --------------------------------------------------------------------------
  logic [7:0] combined_fault_mask_r;
  logic [6:0] fault_flags;
  logic combined_fault;
  logic comb_routed;
  logic [1:0] ctrl_lvl;
  logic [3:0] aux_lvl;
  osr_src_t ctrl_sel [2];
  osr_src_t aux_sel [4];
  logic [3:0] aux_routed;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      combined_fault_mask_r <= OSR_MASK_RST;
    end else if (mask_wr_in) begin
      combined_fault_mask_r <= mask_data_in;
    end
  end

  assign fault_flags = {sources_in.input_error, sources_in.ssr_failure_alarm,
                        sources_in.heater_break_alarm, sources_in.alarm};
  // spare weight masked out so a stray bit cannot raise the output
  assign combined_fault = |(fault_flags & combined_fault_mask_r[OSR_MASK_INERR:OSR_MASK_LIMIT_ALARM_ONE]);

  // --------------------------------------------------------------------------
  // source vector
  // --------------------------------------------------------------------------
  logic [21:0] src_vec;
  logic cool_eff;
  assign cool_eff = heat_cool_mode_in & sources_in.cool;
  assign src_vec = {sources_in.work_bits,
                    combined_fault,
                    sources_in.run_state,
                    sources_in.program_end & program_pattern_on_in,
                    sources_in.input_error,
                    sources_in.ssr_failure_alarm,
                    sources_in.heater_break_alarm,
                    sources_in.heater_alarm,
                    sources_in.alarm,
                    cool_eff,
                    sources_in.heat,
                    1'b0};

  // --------------------------------------------------------------------------
  // variant forcing
  // --------------------------------------------------------------------------
  logic ctrl_present;
  logic [3:0] aux_force;
  assign ctrl_present = (VARIANT == OSR_VAR_STD2);
  assign aux_force[0] = 1'b0;
  assign aux_force[1] = heat_cool_mode_in && ((VARIANT == OSR_VAR_COMPACT) ||
                        (VARIANT == OSR_VAR_STD1 && AUX_COUNT == 2));
  assign aux_force[2] = 1'b0;
  assign aux_force[3] = heat_cool_mode_in && VARIANT == OSR_VAR_STD1 && AUX_COUNT == 4;

  // --------------------------------------------------------------------------
  // control output selectors
  // --------------------------------------------------------------------------
  localparam osr_src_t CTRL_RST [2] = '{OSR_SRC_HEAT, OSR_SRC_OFF};
  for (genvar i = 0; i < 2; i++) begin : g_ctrl
    osr_src_t s;
    logic l;
    osr_selector u_sel (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .reset_sel_in(CTRL_RST[i]),
      .wr_in(ctrl_wr_in[i] & ctrl_present),
      .wr_sel_in(ctrl_sel_in),
      .force_cool_in((i == 1) && heat_cool_mode_in && ctrl_present),
      .logic_used_in(logic_used_in),
      .src_vec_in(src_vec),
      .sel_out(s),
      .level_out(l)
    );
    assign ctrl_sel[i] = s;
    assign ctrl_lvl[i] = l & ctrl_present;
  end

  // --------------------------------------------------------------------------
  // auxiliary output selectors
  // --------------------------------------------------------------------------
  localparam osr_src_t AUX1_RST = HB_HS_FITTED ? OSR_SRC_HEATER : OSR_SRC_LIMIT_ALARM_ONE;
  localparam osr_src_t AUX_RST [4] = '{AUX1_RST, OSR_SRC_ALM2, OSR_SRC_ALM3, OSR_SRC_ALM4};
  for (genvar i = 0; i < OSR_AUX_MAX; i++) begin : g_aux
    if (i < AUX_COUNT) begin : g_on
      osr_src_t s;
      logic l;
      osr_selector u_sel (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .reset_sel_in(AUX_RST[i]),
        .wr_in(aux_wr_in[i]),
        .wr_sel_in(aux_sel_in),
        .force_cool_in(aux_force[i]),
        .logic_used_in(logic_used_in),
        .src_vec_in(src_vec),
        .sel_out(s),
        .level_out(l)
      );
      assign aux_sel[i] = s;
      assign aux_lvl[i] = l;
      assign aux_routed[i] = (aux_sel[i] == OSR_SRC_COMB);
    end else begin : g_off
      assign aux_sel[i] = OSR_SRC_OFF;
      assign aux_lvl[i] = 1'b0;
      assign aux_routed[i] = 1'b0;
    end
  end

  // mask only shows an effect while some output carries the combined fault
  assign comb_routed = (ctrl_present && (ctrl_sel[0] == OSR_SRC_COMB || ctrl_sel[1] == OSR_SRC_COMB))
                       || (|aux_routed);

  logic combined_fault_r;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      combined_fault_r <= 1'b0;
    end else begin
      combined_fault_r <= combined_fault & comb_routed;
    end
  end

  assign ctrl_out = ctrl_lvl;
  assign aux_out = aux_lvl;
  assign combined_fault_mask_out = combined_fault_mask_r;
  assign combined_fault_out = combined_fault_r;
  assign ctrl1_sel_out = ctrl_sel[0];
  assign ctrl2_sel_out = ctrl_sel[1];

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_mask_reset: assert property (@(posedge clk_in) !reset_n_in |=> combined_fault_mask_r == 8'h31)
    else $error("mask reset value wrong");
  a_cool_force: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (heat_cool_mode_in && ctrl_present) |=> ctrl_out[1] == $past(sources_in.cool))
    else $error("output 2 not forced to cooling");
  a_cool_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!heat_cool_mode_in && ctrl_sel[0] == OSR_SRC_COOL) |=> !ctrl_out[0])
    else $error("cooling drive active under standard control");
  a_spare_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (fault_flags & combined_fault_mask_r[6:0]) == 7'h00 |=> !combined_fault_out)
    else $error("combined fault without masked flag");
  a_comb_follow: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (comb_routed && |(fault_flags & combined_fault_mask_r[6:0])) |=> combined_fault_out)
    else $error("combined fault missed");
  a_unrouted_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !comb_routed |=> !combined_fault_out)
    else $error("combined fault with no route");
  a_pend_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!program_pattern_on_in && ctrl_sel[0] == OSR_SRC_PEND && ctrl_present) |=> !ctrl_out[0])
    else $error("program end active with pattern off");
  a_ctrl_absent: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !ctrl_present |-> ctrl_out == 2'h0)
    else $error("control outputs on wrong variant");
  a_heat_route: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ctrl_present && ctrl_sel[0] == OSR_SRC_HEAT && !ctrl_wr_in[0]) |=> ctrl_out[0] == $past(sources_in.heat))
    else $error("heating drive not registered");
  c_comb_on: cover property (@(posedge clk_in) combined_fault_out);
  c_hc_mode: cover property (@(posedge clk_in) heat_cool_mode_in ##1 ctrl_out[1]);
  c_mask_wr: cover property (@(posedge clk_in) mask_wr_in ##1 combined_fault_mask_r == 8'hFF);

endmodule : output_source_router
`default_nettype wire

// File: output_source_router_bench.sv
// self-checking bench for the output source router
`timescale 1ns/1ns
`default_nettype none
module output_source_router_bench
  import osr_pkg::*;
;
  // ----------
  // stimulus and observed signals
  // ----------
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic heat_cool_mode_in = 1'b0;
  logic program_pattern_on_in = 1'b1;
  logic logic_used_in = 1'b1;
  logic [1:0] ctrl_wr_in = 2'h0;
  osr_src_t ctrl_sel_in = OSR_SRC_OFF;
  logic [3:0] aux_wr_in = 4'h0;
  osr_src_t aux_sel_in = OSR_SRC_OFF;
  logic mask_wr_in = 1'b0;
  logic [7:0] mask_data_in = 8'h00;
  osr_sources_t sources_in = '0;
  logic [1:0] ctrl_out;
  logic [3:0] aux_out;
  logic [7:0] combined_fault_mask_out;
  logic combined_fault_out;
  osr_src_t ctrl1_sel_out;
  osr_src_t ctrl2_sel_out;
  logic [1:0] c_ctrl_out;
  logic [3:0] c_aux_out;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  output_source_router i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .heat_cool_mode_in(heat_cool_mode_in),
    .program_pattern_on_in(program_pattern_on_in), .logic_used_in(logic_used_in), .ctrl_wr_in(ctrl_wr_in),
    .ctrl_sel_in(ctrl_sel_in), .aux_wr_in(aux_wr_in), .aux_sel_in(aux_sel_in), .mask_wr_in(mask_wr_in),
    .mask_data_in(mask_data_in), .sources_in(sources_in), .ctrl_out(ctrl_out), .aux_out(aux_out),
    .combined_fault_mask_out(combined_fault_mask_out), .combined_fault_out(combined_fault_out),
    .ctrl1_sel_out(ctrl1_sel_out), .ctrl2_sel_out(ctrl2_sel_out));

  // compact variant with break/ssr detection and two auxiliary outputs, fed from the same inputs
  output_source_router #(.AUX_COUNT(2), .VARIANT(OSR_VAR_COMPACT), .HB_HS_FITTED(1'b1)) i_dut_compact (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .heat_cool_mode_in(heat_cool_mode_in),
    .program_pattern_on_in(program_pattern_on_in), .logic_used_in(logic_used_in), .ctrl_wr_in(ctrl_wr_in),
    .ctrl_sel_in(ctrl_sel_in), .aux_wr_in(aux_wr_in), .aux_sel_in(aux_sel_in), .mask_wr_in(mask_wr_in),
    .mask_data_in(mask_data_in), .sources_in(sources_in), .ctrl_out(c_ctrl_out), .aux_out(c_aux_out),
    .combined_fault_mask_out(), .combined_fault_out(), .ctrl1_sel_out(), .ctrl2_sel_out());

  always #4 clk_in = ~clk_in;

  // whole run is about 120 cycles; the ceiling leaves ample margin
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end

  // ----------
  // shared tasks, entered at a falling edge except tally_and_finish from the timeout at a rising edge
  // ----------
  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick

  task wr_ctrl(input int idx, input osr_src_t code);
    ctrl_sel_in = code;
    ctrl_wr_in[idx] = 1'b1;
    tick(1);
    ctrl_wr_in = 2'h0;
    tick(1);
  endtask : wr_ctrl

  task wr_aux(input int idx, input osr_src_t code);
    aux_sel_in = code;
    aux_wr_in[idx] = 1'b1;
    tick(1);
    aux_wr_in = 4'h0;
    tick(1);
  endtask : wr_aux

  task wr_mask(input logic [7:0] value);
    mask_data_in = value;
    mask_wr_in = 1'b1;
    tick(1);
    mask_wr_in = 1'b0;
    tick(1);
  endtask : wr_mask

  // flag order follows the mask weights: alarms 1-4, break, ssr, input error
  task set_flags(input logic [6:0] f);
    sources_in.alarm = f[3:0];
    sources_in.heater_break_alarm = f[4];
    sources_in.ssr_failure_alarm = f[5];
    sources_in.input_error = f[6];
  endtask : set_flags

  // ----------
  // scenarios
  // ----------
  task t_reset();
    check("ctrl1 sel", ctrl1_sel_out, OSR_SRC_HEAT);
    check("ctrl2 sel", ctrl2_sel_out, OSR_SRC_OFF);
    check("mask", combined_fault_mask_out, 8'h31);
    sources_in.alarm = 4'h5;
    tick(2);
    check("aux defaults", aux_out, 8'h05);
    wr_aux(3, OSR_SRC_HEATER);
    sources_in.heater_alarm = 1'b1;
    tick(2);
    check("aux4 heater", aux_out, 8'h0D);
    sources_in = '0;
  endtask : t_reset

  task t_variant();
    sources_in.heater_alarm = 1'b1;
    sources_in.alarm = 4'h2;
    sources_in.heat = 1'b1;
    tick(2);
    check("compact aux defaults", c_aux_out, 8'h03);
    check("compact ctrl", c_ctrl_out, 8'h00);
    sources_in.alarm = 4'h0;
    sources_in.cool = 1'b1;
    heat_cool_mode_in = 1'b1;
    tick(2);
    check("compact aux2 cool", c_aux_out, 8'h03);
    heat_cool_mode_in = 1'b0;
    sources_in = '0;
  endtask : t_variant

  task t_route();
    wr_ctrl(0, OSR_SRC_ALM2);
    wr_ctrl(1, OSR_SRC_RUN);
    sources_in.alarm = 4'h2;
    sources_in.run_state = 1'b1;
    tick(2);
    check("ctrl routed", ctrl_out, 8'h03);
    sources_in.alarm = 4'h0;
    tick(1);
    check("ctrl1 next edge", ctrl_out, 8'h02);
    sources_in = '0;
  endtask : t_route

  task t_cool();
    wr_ctrl(0, OSR_SRC_COOL);
    sources_in.cool = 1'b1;
    tick(2);
    check("cool std", ctrl_out[0], 8'h00);
    heat_cool_mode_in = 1'b1;
    tick(2);
    check("ctrl2 forced", ctrl2_sel_out, OSR_SRC_COOL);
    check("cool live", ctrl_out, 8'h03);
    heat_cool_mode_in = 1'b0;
    sources_in = '0;
  endtask : t_cool

  task t_pend();
    program_pattern_on_in = 1'b0;
    wr_ctrl(0, OSR_SRC_PEND);
    check("pend sel", ctrl1_sel_out, OSR_SRC_PEND);
    sources_in.program_end = 1'b1;
    tick(2);
    check("pend gated", ctrl_out[0], 8'h00);
    program_pattern_on_in = 1'b1;
    tick(2);
    check("pend live", ctrl_out[0], 8'h01);
    sources_in = '0;
  endtask : t_pend

  task t_work();
    logic_used_in = 1'b0;
    wr_ctrl(0, OSR_SRC_WB3);
    check("wb hidden", ctrl1_sel_out, OSR_SRC_PEND);
    logic_used_in = 1'b1;
    wr_ctrl(0, OSR_SRC_WB3);
    sources_in.work_bits = 8'h04;
    tick(2);
    check("wb sel", ctrl1_sel_out, OSR_SRC_WB3);
    check("wb level", ctrl_out[0], 8'h01);
    sources_in = '0;
  endtask : t_work

  task t_comb();
    wr_ctrl(0, OSR_SRC_COMB);
    for (int i = 0; i < 8; i++) begin
      set_flags(i < 7 ? 7'(1 << i) : 7'h7F);
      wr_mask(8'(1 << i));
      tick(2);
      check("comb own bit", combined_fault_out, (i < 7) ? 8'h01 : 8'h00);
      check("comb routed", ctrl_out[0], (i < 7) ? 8'h01 : 8'h00);
      wr_mask(~8'(1 << i));
      tick(2);
      check("comb other bits", combined_fault_out, (i < 7) ? 8'h00 : 8'h01);
    end
    wr_mask(8'hFF);
    check("mask top", combined_fault_mask_out, 8'hFF);
    wr_ctrl(0, OSR_SRC_OFF);
    tick(2);
    check("comb unrouted", combined_fault_out, 8'h00);
    sources_in = '0;
  endtask : t_comb

  initial begin
    tick(8);
    reset_n_in = 1'b1;
    tick(2);
    t_reset();
    t_variant();
    t_route();
    t_cool();
    t_pend();
    t_work();
    t_comb();
    tally_and_finish();
  end
endmodule : output_source_router_bench
`default_nettype wire
